// file: rtl/cmbc_mode_bus.v
/*
  Bus control bits of the core operating mode register and the expansion
  port sequencer that they steer: arbitration, release timing, transfer
  acknowledge sampling, burst fetch on cache miss, address trace and the
  address attribute priority.
  Assumes the core writes the register only through modeWrite when an
  instruction names it as destination, and that port pins are asynchronous.
*/
`include "cmbc_map.vh"

module cmbc_mode_bus #(
  parameter ADDR_WIDTH = 24,
  parameter DATA_WIDTH = 24,
  parameter ARB_SYNC_STAGES = 2
) (
  input wire mclk, // core clock
  input wire resetn, // async reset, active low
  input wire modeWrite, // explicit write to the mode register
  input wire [`CMBC_MODE_WIDTH-1:0] modeWriteData, // value written
  output reg [`CMBC_MODE_WIDTH-1:0] coreOperatingMode, // readback
  output reg stackExtensionBankSelect, // 1: stack extension in Y space
  input wire cacheMiss, // pulse: instruction cache miss
  input wire [ADDR_WIDTH-1:0] missAddress, // program address missed
  input wire [3:0] attributeMatch, // raw attribute address matches
  input wire intAccessValid, // internal memory access this cycle
  input wire [ADDR_WIDTH-1:0] intAccessAddress, // its address
  input wire busGrantInputN, // bus grant pin, active low
  input wire busBusySignalInN, // bus busy pin level, active low
  output reg busBusySignalOutN, // bus busy drive value, active low
  output reg busBusySignalOe, // bus busy output enable
  input wire transferAcknowledgeInputN, // acknowledge pin, active low
  input wire [DATA_WIDTH-1:0] extDataIn, // external data bus
  output reg [ADDR_WIDTH-1:0] extAddress, // external address lines
  output reg extPortOe, // enable for address and strobe pins
  output reg readStrobeN, // read strobe, active low
  output reg [3:0] addressAttributeOutputs, // attribute lines, active high
  output reg [DATA_WIDTH-1:0] fetchWord, // fetched program word
  output reg fetchWordValid, // pulse: fetchWord is new
  output reg fetchDone // pulse: miss fetch finished
);

  localparam ST_IDLE = 2'h0;
  localparam ST_ARB = 2'h1;
  localparam ST_XFER = 2'h2;
  localparam ST_REL = 2'h3;

  // keep only the highest-numbered active attribute line
  function [3:0] prioPick;
    input [3:0] raw;
    begin
      if (raw[3])
        prioPick = 4'h8;
      else if (raw[2])
        prioPick = 4'h4;
      else if (raw[1])
        prioPick = 4'h2;
      else
        prioPick = {3'h0, raw[0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mode bits

  reg [`CMBC_FIELD_WIDTH-1:0] ctl;
  wire traceOn = ctl[`CMBC_BIT_TRACE-`CMBC_FIELD_LSB];
  wire prioOff = ctl[`CMBC_BIT_ATTR_PRIO_OFF-`CMBC_FIELD_LSB];
  wire asyncArb = ctl[`CMBC_BIT_ASYNC_ARB-`CMBC_FIELD_LSB];
  wire slowRelease = ctl[`CMBC_BIT_RELEASE_TIMING-`CMBC_FIELD_LSB];
  wire ackSync = ctl[`CMBC_BIT_ACK_SYNC-`CMBC_FIELD_LSB];
  wire burstOn = ctl[`CMBC_BIT_BURST-`CMBC_FIELD_LSB];

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      ctl <= `CMBC_FIELD_RESET; // see [R15]
    else if (modeWrite)
      ctl <= modeWriteData[`CMBC_BIT_STACK_BANK:`CMBC_FIELD_LSB]; // see [R14]
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      coreOperatingMode <= {`CMBC_MODE_WIDTH{1'b0}};
      stackExtensionBankSelect <= 1'b0;
    end
    else
    begin
      coreOperatingMode <= {7'h00, ctl, 10'h000};
      stackExtensionBankSelect <= ctl[`CMBC_BIT_STACK_BANK-`CMBC_FIELD_LSB]; // see [R1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling

  reg grantMeta, grantPin, busyMeta, busyPin;
  reg ackMeta, ackPin, ackHeld;
  reg [DATA_WIDTH-1:0] dataMeta, dataPin;
  reg [ARB_SYNC_STAGES-1:0] grantChain, busyChain;

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      grantMeta <= 1'b0;
      grantPin <= 1'b0;
      busyMeta <= 1'b0;
      busyPin <= 1'b0;
      ackMeta <= 1'b0;
      ackPin <= 1'b0;
      ackHeld <= 1'b0;
      dataMeta <= {DATA_WIDTH{1'b0}};
      dataPin <= {DATA_WIDTH{1'b0}};
      grantChain <= {ARB_SYNC_STAGES{1'b0}};
      busyChain <= {ARB_SYNC_STAGES{1'b0}};
    end
    else
    begin
      grantMeta <= ~busGrantInputN;
      grantPin <= grantMeta;
      busyMeta <= ~busBusySignalInN;
      busyPin <= busyMeta;
      ackMeta <= ~transferAcknowledgeInputN;
      ackPin <= ackMeta;
      ackHeld <= ackPin;
      dataMeta <= extDataIn;
      dataPin <= dataMeta;
      grantChain <= {grantChain[ARB_SYNC_STAGES-2:0], grantPin}; // see [R5]
      busyChain <= {busyChain[ARB_SYNC_STAGES-2:0], busyPin}; // see [R5]
    end
  end

  // asynchronous arbitration waits out the extra synchroniser stages;
  // the arbiter's own non-overlap gap keeps two owners apart
  wire granted = asyncArb ? grantChain[ARB_SYNC_STAGES-1] : grantPin; // see [R5] [R6]
  wire otherBusy = asyncArb ? busyChain[ARB_SYNC_STAGES-1] : busyPin; // see [R5]
  // assertion needs one more stable stage when synchronised; removal is
  // taken at once since it is clock-synchronous either way
  wire ackSeen = ackSync ? (ackPin & ackHeld) : ackPin; // see [R9] [R10] [R11]

  ////////////////////////////////////////////////////////////////////////////
  // port sequencer

  reg [1:0] state, next_state;
  reg [2:0] wordsLeft;
  reg ackGap;
  reg [ADDR_WIDTH-1:0] fetchAddress;
  wire lastWord = (wordsLeft == 3'h1);
  wire wordTaken = (state == ST_XFER) && ackSeen && !ackGap;

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (cacheMiss)
          next_state = ST_ARB;
      ST_ARB:
        if (granted && !otherBusy)
          next_state = ST_XFER;
      ST_XFER:
        if (wordTaken && lastWord)
          next_state = slowRelease ? ST_REL : ST_IDLE; // see [R7] [R8]
      ST_REL:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      wordsLeft <= 3'h0;
      ackGap <= 1'b0;
      fetchAddress <= {ADDR_WIDTH{1'b0}};
      fetchWord <= {DATA_WIDTH{1'b0}};
      fetchWordValid <= 1'b0;
      fetchDone <= 1'b0;
    end
    else
    begin
      state <= next_state;
      fetchWordValid <= wordTaken;
      fetchDone <= wordTaken && lastWord;
      // strobe stays high until the old acknowledge has left the sampling
      // flops, so a held level is never taken for the next word
      ackGap <= wordTaken || (ackGap && ackPin);
      if (state == ST_IDLE && cacheMiss)
      begin
        fetchAddress <= missAddress;
        if (burstOn)
          wordsLeft <= `CMBC_BURST_WORDS - {1'b0, missAddress[1:0]}; // see [R13]
        else
          wordsLeft <= `CMBC_SINGLE_WORDS; // see [R12]
      end
      else if (wordTaken)
      begin
        fetchWord <= dataPin;
        wordsLeft <= wordsLeft - 3'h1;
        fetchAddress <= fetchAddress + {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  wire owning = (state == ST_XFER);
  wire tracing = traceOn && intAccessValid && (state == ST_IDLE) && granted
    && !otherBusy;

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      extAddress <= {ADDR_WIDTH{1'b0}};
      extPortOe <= 1'b0;
      readStrobeN <= 1'b1;
      busBusySignalOutN <= 1'b1;
      busBusySignalOe <= 1'b0;
      addressAttributeOutputs <= 4'h0;
    end
    else
    begin
      if (owning)
        extAddress <= fetchAddress;
      else if (tracing)
        extAddress <= intAccessAddress; // see [R2]
      extPortOe <= owning || tracing; // see [R2]
      readStrobeN <= !(owning && !ackGap);
      // slow release keeps busy driven one cycle past the other pins
      busBusySignalOe <= owning || (state == ST_REL); // see [R7] [R8]
      busBusySignalOutN <= !(owning || (state == ST_REL)); // see [R8]
      if (owning || tracing)
        addressAttributeOutputs <= prioOff ? attributeMatch // see [R4]
          : prioPick(attributeMatch); // see [R3]
      else
        addressAttributeOutputs <= 4'h0;
    end
  end

endmodule

// file: rtl/cmbc_map.vh
/*
  Bit positions and reset values of the bus control bits held in the core
  operating mode register, plus the fixed counts of the expansion port.
  Assumes it is included by its bare name from the design file.
*/
// How it works
// [R1] stack extension in X when clear, Y when set
// [R2] trace shows internal access addresses on bus
// [R3] prioritised attributes: highest active line only
// [R4] priority off lets attribute lines combine
// [R5] async arbitration adds grant and busy synchronisers
// [R6] arbiter leaves gap between successive grants
// [R7] fast release: no added cycle
// [R8] slow release: extra cycle, busy released last
// [R9] acknowledge asserted synchronously when sync bit clear
// [R10] sync bit set synchronises acknowledge assertion
// [R11] acknowledge removal always synchronous to clock
// [R12] burst off: one word per cache miss
// [R13] burst on: up to four words per miss
// [R14] bits change only on reset or explicit write
// [R15] reset clears all seven bits
`ifndef CMBC_MAP_VH
`define CMBC_MAP_VH

`define CMBC_MODE_WIDTH 24
`define CMBC_BIT_STACK_BANK 16
`define CMBC_BIT_TRACE 15
`define CMBC_BIT_ATTR_PRIO_OFF 14
`define CMBC_BIT_ASYNC_ARB 13
`define CMBC_BIT_RELEASE_TIMING 12
`define CMBC_BIT_ACK_SYNC 11
`define CMBC_BIT_BURST 10
`define CMBC_FIELD_LSB 10
`define CMBC_FIELD_WIDTH 7
`define CMBC_FIELD_RESET 7'h00
`define CMBC_BURST_WORDS 3'h4
`define CMBC_SINGLE_WORDS 3'h1

`endif

// file: bench/cmbc_mode_bus_chk.sv
/*
  Assertion checker for the mode bus controls.
  Assumes binding to the cmbc_mode_bus ports, one clock domain.
*/
module cmbc_mode_bus_chk (
  input wire mclk, // core clock
  input wire resetn, // async reset, active low
  input wire modeWrite, // register write
  input wire [23:0] modeWriteData, // written value
  input wire [23:0] coreOperatingMode, // readback
  input wire stackExtensionBankSelect, // stack bank
  input wire busBusySignalOutN, // busy drive value
  input wire busBusySignalOe, // busy enable
  input wire extPortOe, // port enable
  input wire readStrobeN, // read strobe
  input wire [3:0] addressAttributeOutputs, // attribute lines
  input wire fetchWordValid, // word pulse
  input wire fetchDone // fetch end
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge mclk); endclocking
default disable iff (!resetn);
wire [23:0] mode = coreOperatingMode;
////////////////////////////////////////////////////////////////////////
a_reset_clears: assert property ($rose(resetn)
  |-> mode == 24'h000000) else $error("mode not clear after reset");
a_write_lands: assert property (modeWrite ##1 !modeWrite |=>
  mode == {7'h00, $past(modeWriteData[16:10], 2), 10'h000})
  else $error("written field not in readback");
a_hold_value: assert property (!modeWrite ##1 !modeWrite
  |=> $stable(mode)) else $error("mode changed without write");
a_bank_follows: assert property (
  stackExtensionBankSelect == mode[16]) else $error("stack bank select wrong");
a_attr_onehot: assert property (!mode[14] && !$past(mode[14])
  |-> $onehot0(addressAttributeOutputs)) else $error("attributes overlap");
a_one_word: assert property (fetchWordValid && !mode[10]
  |-> fetchDone) else $error("more than one word");
a_done_word: assert property (fetchDone |-> fetchWordValid)
  else $error("done without word");
a_slow_release: assert property ($fell(extPortOe) && mode[12]
  |-> busBusySignalOe ##1 !busBusySignalOe) else $error("busy not last");
a_fast_release: assert property ($fell(extPortOe) && !mode[12]
  |-> !busBusySignalOe) else $error("fast release added cycle");
a_ack_synced: assert property ($fell(readStrobeN) && mode[11]
  |-> !fetchWordValid [*4]) else $error("acknowledge not synchronised");
a_busy_driven_low: assert property (busBusySignalOe
  |-> !busBusySignalOutN) else $error("busy driven but not low");
cover property (fetchDone && mode[10]);
cover property (fetchDone && !mode[10]);
cover property ($fell(extPortOe) && mode[12]);
endmodule
bind cmbc_mode_bus cmbc_mode_bus_chk u_cmbc_mode_bus_chk (.mclk(mclk),
  .resetn(resetn), .modeWrite(modeWrite), .modeWriteData(modeWriteData),
  .coreOperatingMode(coreOperatingMode), .extPortOe(extPortOe),
  .stackExtensionBankSelect(stackExtensionBankSelect),
  .busBusySignalOutN(busBusySignalOutN),
  .busBusySignalOe(busBusySignalOe), .readStrobeN(readStrobeN),
  .addressAttributeOutputs(addressAttributeOutputs),
  .fetchWordValid(fetchWordValid), .fetchDone(fetchDone));

// file: bench/cmbc_mem_model.sv
/*
  External program memory on the expansion port.
  Assumes a single bus master; answers after ackDelay cycles.
*/
module cmbc_mem_model (
  input wire mclk, // core clock
  input wire readStrobeN, // read strobe
  input wire extPortOe, // port enable
  input wire [23:0] extAddress, // address lines
  input wire [3:0] ackDelay, // wait cycles
  output logic transferAcknowledgeInputN, // acknowledge, active low
  output logic [23:0] extDataIn // data lines
);
timeunit 1ns;
timeprecision 1ns;
int cnt = 0;
initial transferAcknowledgeInputN = 1'b1;
initial extDataIn = 24'h000000;
always @(posedge mclk)
begin
  #1;
  if (!readStrobeN && extPortOe)
  begin
    extDataIn = extAddress ^ 24'h5A5A5A;
    if (cnt >= ackDelay)
      transferAcknowledgeInputN = 1'b0;
    cnt++;
  end
  else
  begin
    transferAcknowledgeInputN = 1'b1;
    extDataIn = ~extDataIn;
    cnt = 0;
  end
end
endmodule

// file: bench/test_core_mode_bus_controls.sv
/*
  Bench for the mode bus controls: register, fetch, arbitration,
  attributes and trace. Assumes the memory model answers reads.
*/
module test_core_mode_bus_controls;
timeunit 1ns;
timeprecision 1ns;
logic mclk = 0, resetn = 0, modeWrite = 0, cacheMiss = 0, intAccessValid = 0;
logic [23:0] modeWriteData = 0, missAddress = 0, intAccessAddress = 0;
logic [3:0] attributeMatch = 4'hE, ackDelay = 4'h0;
// one master; grant is withdrawn between misses
logic busGrantInputN = 0, busBusySignalInN = 1;
wire [23:0] coreOperatingMode, extAddress, fetchWord, extDataIn;
wire [3:0] addressAttributeOutputs;
wire stackExtensionBankSelect, busBusySignalOutN, busBusySignalOe;
wire transferAcknowledgeInputN, extPortOe, readStrobeN;
wire fetchWordValid, fetchDone;
int err_total = 0, comparisons = 0, lat0, lat1;
cmbc_mode_bus #(.ARB_SYNC_STAGES(2)) u_cmbc_mode_bus (.mclk(mclk),
  .resetn(resetn), .modeWrite(modeWrite), .modeWriteData(modeWriteData),
  .coreOperatingMode(coreOperatingMode), .cacheMiss(cacheMiss),
  .stackExtensionBankSelect(stackExtensionBankSelect),
  .missAddress(missAddress), .attributeMatch(attributeMatch),
  .intAccessValid(intAccessValid), .intAccessAddress(intAccessAddress),
  .busGrantInputN(busGrantInputN), .busBusySignalInN(busBusySignalInN),
  .busBusySignalOutN(busBusySignalOutN), .busBusySignalOe(busBusySignalOe),
  .transferAcknowledgeInputN(transferAcknowledgeInputN),
  .extDataIn(extDataIn), .extAddress(extAddress), .extPortOe(extPortOe),
  .readStrobeN(readStrobeN), .fetchWord(fetchWord), .fetchDone(fetchDone),
  .addressAttributeOutputs(addressAttributeOutputs),
  .fetchWordValid(fetchWordValid));
cmbc_mem_model u_cmbc_mem_model (.mclk(mclk), .readStrobeN(readStrobeN),
  .extPortOe(extPortOe), .extAddress(extAddress), .ackDelay(ackDelay),
  .transferAcknowledgeInputN(transferAcknowledgeInputN),
  .extDataIn(extDataIn));
initial forever #50 mclk = ~mclk;
////////////////////////////////////////////////////////////////////////
task chk(input [23:0] s, input [23:0] e, input string nm);
  comparisons++;
  if (s !== e)
  begin
    err_total++;
    $display("wrong value %s expected %h seen %h", nm, e, s);
  end
endtask
task wr(input [23:0] d);
  @(negedge mclk) modeWrite = 1;
  modeWriteData = d;
  @(negedge mclk) modeWrite = 0;
  @(negedge mclk);
endtask
// one miss; checks words, addresses and attribute lines
task fetch(input [23:0] a, input int n, input [3:0] at, output int lat);
  int k, w;
  reg [23:0] e;
  // grant withdrawn, then given back with the miss: latency counts from it
  @(negedge mclk) busGrantInputN = 1;
  repeat (6) @(negedge mclk);
  cacheMiss = 1;
  busGrantInputN = 0;
  missAddress = a;
  @(negedge mclk) cacheMiss = 0;
  lat = 1;
  w = 0;
  e = a;
  while (readStrobeN !== 1'b0 && lat < 50)
  begin
    @(negedge mclk);
    lat++;
  end
  chk(extAddress, a, "first address");
  chk({20'h0, addressAttributeOutputs}, {20'h0, at}, "attr");
  for (k = 0; k < 200; k++)
  begin
    if (fetchWordValid === 1'b1)
    begin
      chk(fetchWord, e ^ 24'h5A5A5A, "fetch word");
      e++;
      w++;
    end
    if (fetchDone === 1'b1)
      k = 200;
    @(negedge mclk);
  end
  chk(w[23:0], n[23:0], "word count");
endtask
task wrap_up;
  $display("errors %0d comparisons %0d", err_total, comparisons);
  if (err_total == 0 && comparisons > 0)
    $display("TEST PASSED");
  else
    $display("TEST FAILED");
  $finish;
endtask
initial
begin
  #3000000;
  err_total++;
  wrap_up();
end
initial
begin
  repeat (8) @(negedge mclk);
  resetn = 1;
  @(negedge mclk);
  chk(coreOperatingMode, 24'h000000, "reset mode");
  wr(24'hFFFFFF);
  chk(coreOperatingMode, 24'h01FC00, "mode field");
  chk({23'h0, stackExtensionBankSelect}, 24'h1, "bank Y");
  wr(24'hFEFFFF);
  chk({23'h0, stackExtensionBankSelect}, 24'h0, "bank X");
  wr(24'h000000);
  fetch(24'h000102, 1, 4'h8, lat0);
  wr(24'h005C00);
  fetch(24'h000201, 3, 4'hE, lat1);
  ackDelay = 4'h3;
  fetch(24'h000300, 4, 4'hE, lat1);
  ackDelay = 4'h0;
  wr(24'h002000);
  fetch(24'h000103, 1, 4'h8, lat1);
  chk(lat1[23:0] - lat0[23:0], 24'h2, "async delay");
  wr(24'h008000);
  @(negedge mclk) intAccessValid = 1;
  intAccessAddress = 24'h00ABCD;
  @(negedge mclk) intAccessValid = 0;
  chk(extAddress, 24'h00ABCD, "trace address");
  chk({23'h0, extPortOe}, 24'h1, "trace drive");
  chk({20'h0, addressAttributeOutputs}, 24'h8, "trace attr");
  wrap_up();
end
endmodule
